// ### rtl/input_function_pkg.sv
// Package for the input function assignment block: function codes, reset codes, sizes.
// Assumes a single clock domain and no register bus; settings arrive on plain ports.
package input_function_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_TERMINALS = 8;
  localparam int CODE_WIDTH = 8;
  localparam int NUM_GENERAL = 16;
  localparam int NUM_DIRECT_POS = 6;
  localparam int DATA_SEL_WIDTH = 6;

  typedef logic [CODE_WIDTH-1:0] func_code_t;

  // ****************************************************************
  // Function codes
  // ****************************************************************
  localparam func_code_t CODE_UNUSED = 8'h00;
  localparam func_code_t CODE_CONT_POS = 8'h01;
  localparam func_code_t CODE_CONT_NEG = 8'h02;
  localparam func_code_t CODE_HOME = 8'h03;
  localparam func_code_t CODE_START = 8'h04;
  localparam func_code_t CODE_SEQ_START = 8'h05;
  localparam func_code_t CODE_JOG_POS = 8'h06;
  localparam func_code_t CODE_JOG_NEG = 8'h07;
  localparam func_code_t CODE_DIRECT_POS_FIRST = 8'h08;
  localparam func_code_t CODE_DIRECT_POS_LAST = 8'h0D;
  localparam func_code_t CODE_FREE = 8'h10;
  localparam func_code_t CODE_EXCITE_TOGGLE = 8'h11;
  localparam func_code_t CODE_STOP = 8'h12;
  localparam func_code_t CODE_ALARM_CLEAR = 8'h18;
  localparam func_code_t CODE_POS_PRESET = 8'h19;
  localparam func_code_t CODE_TOOL_RELEASE = 8'h1B;
  localparam func_code_t CODE_GENERAL_FIRST = 8'h20;
  localparam func_code_t CODE_DATA_SEL_FIRST = 8'h30;
  localparam func_code_t CODE_DATA_SEL_LAST = 8'h35;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam func_code_t RESET_CODE [NUM_TERMINALS] = '{
    8'h03, 8'h04, 8'h30, 8'h31, 8'h32, 8'h10, 8'h12, 8'h18
  };
  localparam logic [NUM_TERMINALS-1:0] RESET_LOGIC_LEVEL = 8'h00;

endpackage : input_function_pkg

// ### rtl/input_function_assignment.sv
// Input function assignment: maps eight direct terminals and eight network inputs to functions.
// Assumes terminal pins are asynchronous, network inputs and settings come from clk_sys logic.
//
// Overview of operation
// R1 - Eight direct terminals, each routed to one function by its own code.
// R2 - Terminals zero to three reset to home, start, select bit 0, select bit 1.
// R3 - Terminals four to seven reset to select bit 2, free, stop, alarm clear.
// R4 - Code zero marks a terminal unused; it drives nothing.
// R5 - Codes one and two request continuous positive and negative motion.
// R6 - Codes three, four, five request home, positioning, sequential positioning.
// R7 - Codes six and seven request positive and negative jog.
// R8 - Codes eight to thirteen request the six direct positioning starts.
// R9 - Code sixteen removes excitation and releases the brake while active.
// R10 - Code seventeen switches between excited and non-excited states.
// R11 - Code eighteen requests a stop of the present motion.
// R12 - Code twenty-four clears the alarm; twenty-five presets the position.
// R13 - Code twenty-seven lifts the setting tool limitation.
// R14 - Codes thirty-two to forty-seven map onto sixteen general signals.
// R15 - Codes forty-eight to fifty-three form the six-bit data number.
// R16 - Code forty-eight is the data number LSB; unassigned bits read zero.
// R17 - One function on several terminals acts when any is active.
// R18 - Alarm clear and position preset act only on an inactive-to-active edge.
// R19 - Tool release with no direct terminal assigned counts as always active.
// R20 - Tool release assigned on both direct and network acts only when both active.
// R21 - A second, identical set of inputs arrives over the serial network.
// R22 - Function codes are writable by the setting tools or the network.
// R23 - Codes missing from the table drive nothing, like code zero.
// R24 - Each terminal has a logic level: zero normally open, one inverted.
`timescale 1ns/1ns

module input_function_assignment
  import input_function_pkg::*;
#(
  parameter int TERMINALS = input_function_pkg::NUM_TERMINALS
)
(
  input wire logic clk_sys, // System clock, 10 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [TERMINALS-1:0] input_terminal, // Direct terminal pins.
  input wire logic [TERMINALS-1:0] net_input, // Network inputs, same clock.
  input wire logic code_wr, // Write strobe for one direct terminal code.
  input wire logic net_code_wr, // Write strobe for one network input code.
  input wire logic [2:0] code_wr_index, // Slot selected by either code write.
  input wire input_function_pkg::func_code_t code_wr_data, // Function code written.
  input wire logic level_wr, // Write strobe for the logic level settings.
  input wire logic [TERMINALS-1:0] level_wr_data, // New logic levels, one per terminal.
  output logic continuous_positive, // Continuous positive motion request.
  output logic continuous_negative, // Continuous negative motion request.
  output logic home_start, // Return-to-home request.
  output logic position_start, // Positioning request.
  output logic sequential_positioning_start, // Sequential positioning request.
  output logic jog_positive, // Positive jog request.
  output logic jog_negative, // Negative jog request.
  output logic [5:0] direct_position_start, // Direct positioning starts.
  output logic free_run, // Excitation off and brake released.
  output logic excitation_toggle, // Excitation switching input.
  output logic stop_request, // Stop request.
  output logic alarm_clear, // One-cycle alarm clear pulse.
  output logic position_preset, // One-cycle position preset pulse.
  output logic tool_limit_release, // Setting tool limitation lifted.
  output logic [15:0] general_signal, // General purpose signals.
  output logic [5:0] data_select // Operation data number.
);

  // Refuses a terminal count that the eight code slots and the 3-bit index cannot serve.
  if (TERMINALS != NUM_TERMINALS)
  begin : g_bad_terminals
    $error("input_function_assignment supports exactly eight terminals");
  end

  // ****************************************************************
  // Settings
  // ****************************************************************
  func_code_t code_ff [TERMINALS];
  func_code_t net_code_ff [TERMINALS];
  logic [TERMINALS-1:0] level_ff;

  // Direct terminal codes, written one slot at a time.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < TERMINALS; i++)
      begin
        code_ff[i] <= RESET_CODE[i]; // R2 R3
      end
    end
    else if (code_wr)
    begin
      code_ff[code_wr_index] <= code_wr_data; // R1 R22
    end
  end

  // Network input codes; all start unused.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < TERMINALS; i++)
      begin
        net_code_ff[i] <= CODE_UNUSED;
      end
    end
    else if (net_code_wr)
    begin
      net_code_ff[code_wr_index] <= code_wr_data; // R21 R22
    end
  end

  // Logic level settings.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      level_ff <= RESET_LOGIC_LEVEL;
    end
    else if (level_wr)
    begin
      level_ff <= level_wr_data;
    end
  end

  // ****************************************************************
  // Terminal synchroniser and logic level
  // ****************************************************************
  logic [TERMINALS-1:0] sync1_ff;
  logic [TERMINALS-1:0] sync2_ff;

  // Two flip-flops before any logic reads a pin.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= input_terminal;
      sync2_ff <= sync1_ff;
    end
  end

  logic [TERMINALS-1:0] term_active;
  assign term_active = sync2_ff ^ level_ff; // R24

  // ****************************************************************
  // Decoding
  // ****************************************************************
  // Bit n of a map is function code n; only table codes, up to 53, set a bit.
  logic [63:0] dir_map [TERMINALS];
  logic [63:0] net_map [TERMINALS];

  // Returns a one-hot for an active table code; inactive inputs, unused and missing codes give zero.
  function automatic logic [63:0] decode(input func_code_t code, input logic act);
    logic [63:0] v;
    logic ok;
    v = '0;
    ok = (code >= CODE_CONT_POS && code <= CODE_DIRECT_POS_LAST) || (code >= CODE_FREE && code <= CODE_STOP) ||
         code == CODE_ALARM_CLEAR || code == CODE_POS_PRESET || code == CODE_TOOL_RELEASE ||
         (code >= CODE_GENERAL_FIRST && code <= CODE_DATA_SEL_LAST); // R4 R23
    if (ok && act)
    begin
      v[code[5:0]] = 1'b1;
    end
    return v;
  endfunction : decode

  genvar g;
  generate
    for (g = 0; g < TERMINALS; g++)
    begin : g_term
      assign dir_map[g] = decode(code_ff[g], term_active[g]); // R1
      assign net_map[g] = decode(net_code_ff[g], net_input[g]); // R21
    end
  endgenerate

  logic [63:0] dir_any;
  logic [63:0] net_any;
  logic [63:0] all_any;
  logic dir_tool_assigned;
  logic net_tool_assigned;

  // OR of every source that carries a function.
  always_comb
  begin
    dir_any = '0;
    net_any = '0;
    dir_tool_assigned = 1'b0;
    net_tool_assigned = 1'b0;
    for (int i = 0; i < TERMINALS; i++)
    begin
      dir_any = dir_any | dir_map[i]; // R17
      net_any = net_any | net_map[i]; // R17
      dir_tool_assigned = dir_tool_assigned | (code_ff[i] == CODE_TOOL_RELEASE);
      net_tool_assigned = net_tool_assigned | (net_code_ff[i] == CODE_TOOL_RELEASE);
    end
    all_any = dir_any | net_any;
  end

  logic dir_tool;
  logic net_tool;
  assign dir_tool = dir_tool_assigned ? dir_any[CODE_TOOL_RELEASE[5:0]] : 1'b1; // R19
  assign net_tool = net_tool_assigned ? net_any[CODE_TOOL_RELEASE[5:0]] : 1'b1;

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  logic alarm_prev_ff;
  logic preset_prev_ff;

  // Level functions are registered straight from the combined maps; tool release comes from the AND of the direct and network sides.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      continuous_positive <= 1'b0;
      continuous_negative <= 1'b0;
      home_start <= 1'b0;
      position_start <= 1'b0;
      sequential_positioning_start <= 1'b0;
      jog_positive <= 1'b0;
      jog_negative <= 1'b0;
      direct_position_start <= '0;
      free_run <= 1'b0;
      excitation_toggle <= 1'b0;
      stop_request <= 1'b0;
      tool_limit_release <= 1'b0;
      general_signal <= '0;
      data_select <= '0;
    end
    else
    begin
      continuous_positive <= all_any[CODE_CONT_POS[5:0]]; // R5
      continuous_negative <= all_any[CODE_CONT_NEG[5:0]]; // R5
      home_start <= all_any[CODE_HOME[5:0]]; // R6
      position_start <= all_any[CODE_START[5:0]]; // R6
      sequential_positioning_start <= all_any[CODE_SEQ_START[5:0]]; // R6
      jog_positive <= all_any[CODE_JOG_POS[5:0]]; // R7
      jog_negative <= all_any[CODE_JOG_NEG[5:0]]; // R7
      direct_position_start <= all_any[CODE_DIRECT_POS_FIRST[5:0] +: NUM_DIRECT_POS]; // R8
      free_run <= all_any[CODE_FREE[5:0]]; // R9
      excitation_toggle <= all_any[CODE_EXCITE_TOGGLE[5:0]]; // R10
      stop_request <= all_any[CODE_STOP[5:0]]; // R11
      tool_limit_release <= dir_tool & net_tool; // R13 R20
      general_signal <= all_any[CODE_GENERAL_FIRST[5:0] +: NUM_GENERAL]; // R14
      data_select <= all_any[CODE_DATA_SEL_FIRST[5:0] +: DATA_SEL_WIDTH]; // R15 R16
    end
  end

  // Edge-triggered functions fire once per inactive-to-active transition.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_prev_ff <= 1'b0;
      preset_prev_ff <= 1'b0;
      alarm_clear <= 1'b0;
      position_preset <= 1'b0;
    end
    else
    begin
      alarm_prev_ff <= all_any[CODE_ALARM_CLEAR[5:0]];
      preset_prev_ff <= all_any[CODE_POS_PRESET[5:0]];
      alarm_clear <= all_any[CODE_ALARM_CLEAR[5:0]] & ~alarm_prev_ff; // R12 R18
      position_preset <= all_any[CODE_POS_PRESET[5:0]] & ~preset_prev_ff; // R12 R18
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_ALARM_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst) // R18
    alarm_clear |=> !alarm_clear)
    else $error("alarm clear lasted more than one cycle");

  AST_PRESET_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst) // R18
    position_preset |=> !position_preset)
    else $error("position preset lasted more than one cycle");

  AST_ALARM_EDGE: assert property (@(posedge clk_sys) disable iff (!nrst) // R12
    (all_any[CODE_ALARM_CLEAR[5:0]] && !$past(all_any[CODE_ALARM_CLEAR[5:0]])) |=> alarm_clear)
    else $error("alarm clear missed a rising request");

  AST_TOOL_DEFAULT: assert property (@(posedge clk_sys) disable iff (!nrst) // R19
    (!dir_tool_assigned && !net_tool_assigned) |=> tool_limit_release)
    else $error("tool release not active while unassigned");

  AST_TOOL_AND: assert property (@(posedge clk_sys) disable iff (!nrst) // R20
    (dir_tool_assigned && net_tool_assigned &&
     !(dir_any[CODE_TOOL_RELEASE[5:0]] && net_any[CODE_TOOL_RELEASE[5:0]])) |=> !tool_limit_release)
    else $error("tool release active without both sources");

  AST_STOP_OR: assert property (@(posedge clk_sys) disable iff (!nrst) // R17
    (code_ff[0] == CODE_STOP && term_active[0]) |=> stop_request)
    else $error("stop not seen from an active terminal");

  AST_UNUSED: assert property (@(posedge clk_sys) disable iff (!nrst) // R4
    (code_ff[0] == CODE_UNUSED) |-> dir_map[0] == '0)
    else $error("unused terminal drove a function");

  AST_MISSING_CODE: assert property (@(posedge clk_sys) disable iff (!nrst) // R23
    (code_ff[0] == 8'h0E || code_ff[0] == 8'h13) |-> dir_map[0] == '0)
    else $error("missing code drove a function");

  AST_DATA_SEL: assert property (@(posedge clk_sys) disable iff (!nrst) // R16
    (all_any[CODE_DATA_SEL_FIRST[5:0] +: DATA_SEL_WIDTH] == 6'h00) |=> data_select == 6'h00)
    else $error("data number not zero with no select bits");

endmodule : input_function_assignment

// ### dv/host_model.sv
// Host model: drives the direct terminal pins and the network input bits.
// Assumes one clk_sys domain; the bench calls its tasks to change levels.
`timescale 1ns/1ns

module host_model
(
  input wire logic clk_sys, // System clock.
  output logic [7:0] input_terminal, // Pins to the block.
  output logic [7:0] net_input // Network input bits.
);
  // Lines idle low until the host drives them.
  initial
  begin
    input_terminal = 8'h00;
    net_input = 8'h00;
  end

  // Pin levels change just after a clock edge and then stand.
  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_sys);
    input_terminal <= v;
  endtask : set_pins

  // The host may send one function from several sources at once.
  task automatic set_net(input logic [7:0] v);
    @(posedge clk_sys);
    net_input <= v;
  endtask : set_net
endmodule : host_model

// ### dv/input_function_assignment_tb.sv
// Bench for the input function assignment block.
// Assumes the host model drives pins and network bits; settings are written by tasks here.
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module input_function_assignment_tb;
  import input_function_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] input_terminal, net_input;
  logic code_wr = 1'b0;
  logic net_code_wr = 1'b0;
  logic [2:0] code_wr_index = 3'h0;
  func_code_t code_wr_data = 8'h00;
  logic level_wr = 1'b0;
  logic [7:0] level_wr_data = 8'h00;
  logic continuous_positive, continuous_negative, home_start, position_start, sequential_positioning_start;
  logic jog_positive, jog_negative, free_run, excitation_toggle, stop_request;
  logic alarm_clear, position_preset, tool_limit_release;
  logic [5:0] direct_position_start, data_select;
  logic [15:0] general_signal;
  logic [37:0] obs;
  int failures = 0;
  int samples_checked = 0;
  int n_clr = 0;
  int n_pre = 0;
  int rst_code [8] = '{3, 4, 48, 49, 50, 16, 18, 24};

  // ****************************************************************
  // Design, host and observation
  // ****************************************************************
  input_function_assignment u_dut (.clk_sys, .nrst, .input_terminal, .net_input, .code_wr, .net_code_wr,
    .code_wr_index, .code_wr_data, .level_wr, .level_wr_data, .continuous_positive, .continuous_negative,
    .home_start, .position_start, .sequential_positioning_start, .jog_positive, .jog_negative,
    .direct_position_start, .free_run, .excitation_toggle, .stop_request, .alarm_clear, .position_preset,
    .tool_limit_release, .general_signal, .data_select);
  host_model u_host (.clk_sys, .input_terminal, .net_input);

  // All level outputs except tool release side by side, one bit per function.
  assign obs = {continuous_positive, continuous_negative, home_start, position_start, sequential_positioning_start,
    jog_positive, jog_negative, direct_position_start, free_run, excitation_toggle, stop_request,
    general_signal, data_select};

  // The clock runs at 10 MHz.
  always #50 clk_sys = ~clk_sys;

  // Pulse outputs are counted one per cycle high.
  always @(posedge clk_sys)
  begin
    if (alarm_clear === 1'b1) n_clr++;
    if (position_preset === 1'b1) n_pre++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic logic [37:0] exp_of(input int c);
    logic [37:0] v;
    v = '0;
    if (c >= 1 && c <= 7) v[38 - c] = 1'b1;
    else if (c >= 8 && c <= 13) v[c + 17] = 1'b1;
    else if (c >= 16 && c <= 18) v[40 - c] = 1'b1;
    else if (c >= 32 && c <= 47) v[c - 26] = 1'b1;
    else if (c >= 48 && c <= 53) v[c - 48] = 1'b1;
    return v;
  endfunction : exp_of

  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask : settle

  task automatic wr_code(input logic net, input logic [2:0] idx, input int c);
    @(posedge clk_sys);
    code_wr <= ~net;
    net_code_wr <= net;
    code_wr_index <= idx;
    code_wr_data <= func_code_t'(c);
    @(posedge clk_sys);
    code_wr <= 1'b0;
    net_code_wr <= 1'b0;
  endtask : wr_code

  task automatic set_level(input logic [7:0] v);
    @(posedge clk_sys);
    level_wr <= 1'b1;
    level_wr_data <= v;
    @(posedge clk_sys);
    level_wr <= 1'b0;
    settle();
  endtask : set_level

  task automatic drive(input logic net, input logic [7:0] v);
    if (net) u_host.set_net(v);
    else u_host.set_pins(v);
    settle();
  endtask : drive

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Cuts a hung run short.
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    logic [37:0] e;
    e = '0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    settle();
    `CHK(obs, 38'h00_0000_0000)
    `CHK(tool_limit_release, 1'b1)
    for (int i = 0; i < 7; i++) e |= exp_of(rst_code[i]);
    drive(1'b0, 8'hff);
    `CHK(obs, e)
    `CHK(n_clr, 1)
    drive(1'b0, 8'h00);
    // Codes zero to sixty-three on a direct slot, then on a network slot.
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 64; c++)
      begin
        wr_code(s[0], 3'h0, c);
        n_clr = 0;
        n_pre = 0;
        drive(s[0], 8'h01);
        `CHK(obs, exp_of(c))
        `CHK(tool_limit_release, 1'b1)
        `CHK(n_clr, (c == 24) ? 1 : 0)
        `CHK(n_pre, (c == 25) ? 1 : 0)
        drive(s[0], 8'h00);
        `CHK(obs, 38'h00_0000_0000)
        `CHK(tool_limit_release, (c != 27))
        `CHK(n_clr + n_pre, (c == 24 || c == 25) ? 1 : 0)
      end
    // Inverted logic level on the terminal that starts positioning.
    set_level(8'h02);
    `CHK(obs, exp_of(4))
    drive(1'b0, 8'h02);
    `CHK(obs, 38'h00_0000_0000)
    set_level(8'h00);
    drive(1'b0, 8'h00);
    // Stop on two terminals, alarm clear on a pin and a network bit.
    wr_code(1'b0, 3'h5, 18);
    drive(1'b0, 8'h20);
    `CHK(obs, exp_of(18))
    drive(1'b0, 8'h60);
    drive(1'b0, 8'h40);
    `CHK(obs, exp_of(18))
    drive(1'b0, 8'h00);
    `CHK(obs, 38'h00_0000_0000)
    wr_code(1'b1, 3'h7, 24);
    n_clr = 0;
    drive(1'b0, 8'h80);
    drive(1'b1, 8'h80);
    drive(1'b0, 8'h00);
    `CHK(n_clr, 1)
    drive(1'b1, 8'h00);
    drive(1'b1, 8'h80);
    `CHK(n_clr, 2)
    drive(1'b1, 8'h00);
    // Tool release on both sides needs both active.
    wr_code(1'b0, 3'h0, 27);
    wr_code(1'b1, 3'h0, 27);
    for (int k = 0; k < 4; k++)
    begin
      u_host.set_pins({7'h00, k[0]});
      drive(1'b1, {7'h00, k[1]});
      `CHK(tool_limit_release, (k == 3))
    end
    // A second reset restores every code, so the defaults act again.
    drive(1'b0, 8'h00);
    drive(1'b1, 8'h00);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    settle();
    `CHK(tool_limit_release, 1'b1)
    n_clr = 0;
    drive(1'b0, 8'hff);
    `CHK(obs, e)
    `CHK(n_clr, 1)
    drive(1'b0, 8'h00);
    drive(1'b1, 8'h80);
    `CHK(n_clr, 1)
    wrap_up();
  end
endmodule : input_function_assignment_tb
